//--- rtl/periodic_timer.sv
// Purpose: 10-bit periodic timer with compare, PWM, pulse, capture modes
// Assumes: control bits and compare values are plain same-clock ports;
//          the capture pin and the counting tick come from outside
// Notes:   one timer tick per core clock when tick is high
// Behaviour
// - Mode 11 acts as compare mode, pin released
// - Timer/counter mode releases the output pin
// - Mode 10: period clears counter, duty sets duty
// - Period 0 gives 1024 counts, else value
// - Duty at or above period gives 100%
// - PWM sets flags on duty and period match
// - Output control, io field, polarity shape PWM
// - PWM counting continues when io is 00/01
// - Run rising edge starts pulse and counter
// - Duty match or run clear ends pulse
// - Pulse mode: counter clears only on run rise
// - Mode 01 captures on io-selected edges; 11 off
// - Capture edge copies counter, raises flag
// - Capture mode counter free-runs while run high
// - Capture period match clears counter, raises flag
// - Capture period 0 counts to full maximum
// - Capture mode ignores clear select, oc, polarity
// - Clear select 1: duty match clears, no period flag
// - Only duty flag sets/clears/toggles pin per io; run rise resets
// - Capture source is the dedicated capture pin
// - Clear select 0: period match or overflow clears
// - Counter and compare values are 10 bits
`timescale 1ns/10ps
`include "periodic_timer_map.svh"
module periodic_timer #(
  parameter int CNT_W = `PT_CNT_W
) (
  input  wire logic                         core_clk_in,
  input  wire logic                         rst_n_in,
  input  wire logic                         tick_in,
  input  wire periodic_timer_pkg::mode_type mode_field_in,
  input  wire periodic_timer_pkg::io_type   io_field_in,
  input  wire logic                         run_bit_set_in,
  input  wire logic                         run_bit_clr_in,
  input  wire logic                         output_control_bit_in,
  input  wire logic                         polarity_bit_in,
  input  wire logic                         counter_clear_select_in,
  input  wire logic                         capture_source_select_in,
  input  wire logic                         capture_input_pin_in,
  input  wire periodic_timer_pkg::count_type duty_compare_value_in,
  input  wire logic                         duty_compare_write_in,
  input  wire periodic_timer_pkg::count_type period_compare_value_in,
  input  wire logic                         duty_flag_clr_in,
  input  wire logic                         period_flag_clr_in,
  output logic                              run_bit_out,
  output periodic_timer_pkg::count_type     count_out,
  output periodic_timer_pkg::count_type     duty_compare_value_out,
  output logic                              duty_match_flag_out,
  output logic                              period_match_flag_out,
  output logic                              pin_out,
  output logic                              pin_oe_out
);
  import periodic_timer_pkg::*;

  // The compare registers, the codes and the wrap at full count all assume
  // ten bits; a different width would silently change the PWM period
  generate
    if (CNT_W != `PT_CNT_W) begin : g_width_check
      $error("periodic_timer supports only a 10-bit counter");
    end
  endgenerate

  // Registered state and the next-state terms of counter and pin
  logic      cap_meta_r;
  logic      cap_sync_r;
  logic      cap_prev_r;
  logic      run_prev_r;
  count_type cnt_r;
  count_type cnt_nxt;
  count_type duty_r;
  logic      run_r;
  logic      level_r;
  logic [1:0] flag_r;
  logic      pin_nxt;
  logic      oe_nxt;
  logic      pin_r;
  logic      oe_r;

  // Combinational decode and match terms
  logic      run_rise;
  logic      cmp_like;
  logic      is_pwm;
  logic      is_pulse;
  logic      is_cap;
  logic      duty_hit;
  logic      period_hit;
  logic      ovf_hit;
  logic      cap_edge;
  logic      duty_evt;
  logic      period_evt;
  logic      pwm_active;
  logic      cap_rise;
  logic      cap_fall;
  logic      pwm_wrap;
  logic [1:0] flag_evt;
  logic [1:0] flag_clr;
  count_type period_last;

  // Mode decode; single pulse is the PWM code with io fixed at 11, so the
  // io field must not move while a pulse is running
  assign run_rise = run_r & ~run_prev_r;
  assign cmp_like = (mode_field_in == `PT_MODE_CMP) |
                    (mode_field_in == `PT_MODE_TMR);
  assign is_pwm   = (mode_field_in == `PT_MODE_PWM) &
                    (io_field_in != `PT_IO_11);
  assign is_pulse = (mode_field_in == `PT_MODE_PWM) &
                    (io_field_in == `PT_IO_11);
  assign is_cap   = (mode_field_in == `PT_MODE_CAP);

  // Comparisons are taken only on a counting tick, once per tick
  assign duty_hit   = run_r & tick_in & (cnt_r == duty_r);
  assign period_hit = run_r & tick_in &
                      (period_compare_value_in != `PT_CNT_ZERO) &
                      (cnt_r == period_compare_value_in);
  assign ovf_hit    = run_r & tick_in & (cnt_r == `PT_CNT_MAX) &
                      (period_compare_value_in == `PT_CNT_ZERO);

  // PWM wraps one count early, so a period value p gives exactly p counts
  // and a value of 0 rolls over naturally after 1024
  assign period_last = period_compare_value_in - 10'h001;
  assign pwm_wrap    = run_r & tick_in &
                       (period_compare_value_in != `PT_CNT_ZERO) &
                       (cnt_r == period_last);

  // Only the dedicated pin exists; the select bit has a single legal value.
  // Setting the select bit therefore blocks capture rather than guessing
  assign cap_rise = cap_sync_r & ~cap_prev_r & ~capture_source_select_in;
  assign cap_fall = ~cap_sync_r & cap_prev_r & ~capture_source_select_in;
  always_comb begin
    case (io_field_in)
      `PT_IO_00: cap_edge = cap_rise;
      `PT_IO_01: cap_edge = cap_fall;
      `PT_IO_10: cap_edge = cap_rise | cap_fall;
      default:   cap_edge = 1'b0;
    endcase
  end

  // Flag events per mode. Compare mode with duty 0 raises no duty flag,
  // since the duty value is not meant to be zero there; the counter then
  // simply overflows.
  always_comb begin
    duty_evt   = 1'b0;
    period_evt = 1'b0;
    if (cmp_like) begin
      duty_evt   = duty_hit & (duty_r != `PT_CNT_ZERO);
      period_evt = counter_clear_select_in ? 1'b0 :
                   (period_hit | ovf_hit);
    end else if (is_pwm) begin
      duty_evt   = duty_hit;
      period_evt = pwm_wrap | ovf_hit;
    end else if (is_pulse) begin
      duty_evt   = duty_hit;
    end else if (is_cap) begin
      duty_evt   = run_r & cap_edge;
      period_evt = period_hit;
    end
  end

  // Counter: clears on run rise, per-mode clear on match, holds when off.
  // A run fall keeps the residual count, so software may read it back
  // after stopping.
  always_comb begin
    cnt_nxt = cnt_r;
    if (run_rise) begin
      cnt_nxt = `PT_CNT_ZERO;
    end else if (run_r & tick_in) begin
      cnt_nxt = cnt_r + 10'h001;
      if (cmp_like) begin
        if (counter_clear_select_in) begin
          if (duty_hit & (duty_r != `PT_CNT_ZERO))
            cnt_nxt = `PT_CNT_ZERO;
        end else if (period_hit) begin
          cnt_nxt = `PT_CNT_ZERO;
        end
      end else if (is_pwm) begin
        if (pwm_wrap)
          cnt_nxt = `PT_CNT_ZERO;
      end else if (is_cap) begin
        if (period_hit)
          cnt_nxt = `PT_CNT_ZERO;
      end else if (is_pulse & duty_hit) begin
        // Stopped on the match; only the next run rise restarts it
        cnt_nxt = cnt_r;
      end
    end
  end

  // Capture pin synchroniser; only the second stage feeds the edge logic
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cap_meta_r <= 1'b0;
      cap_sync_r <= 1'b0;
    end else begin
      cap_meta_r <= capture_input_pin_in;
      cap_sync_r <= cap_meta_r;
    end
  end

  // Edge history of the synchronised pin; its reset matches the low idle
  // level, so no false rising edge follows reset on a quiet pin
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      cap_prev_r <= 1'b0;
    else
      cap_prev_r <= cap_sync_r;
  end

  // Run bit: software sets and clears, a pulse-mode duty match clears it;
  // set wins so a restart is never lost to a late clear
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      run_r <= 1'b0;
    else if (run_bit_set_in)
      run_r <= 1'b1;
    else if (run_bit_clr_in | (is_pulse & duty_hit))
      run_r <= 1'b0;
  end

  // Delayed copy of run, so its rising edge shows for exactly one clock
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      run_prev_r <= 1'b0;
    else
      run_prev_r <= run_r;
  end

  // Counter register; the next value is worked out above
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      cnt_r <= `PT_CNT_ZERO;
    else
      cnt_r <= cnt_nxt;
  end

  // Duty register: written by software, loaded by capture. Capture wins
  // over a write in the same cycle: the measured edge is the fresher
  // information
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      duty_r <= `PT_CNT_ZERO;
    else if (is_cap & run_r & cap_edge)
      duty_r <= cnt_r;
    else if (duty_compare_write_in)
      duty_r <= duty_compare_value_in;
  end

  // Both flags share one shape, so one loop serves them
  assign flag_evt = {period_evt, duty_evt};
  assign flag_clr = {period_flag_clr_in, duty_flag_clr_in};

  // Sticky flags, bit 0 duty and bit 1 period; a new event wins over a
  // clear in the same cycle, so software that clears late loses no match
  for (genvar g = 0; g < 2; g++) begin : g_flag
    always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in)
        flag_r[g] <= 1'b0;
      else if (flag_evt[g])
        flag_r[g] <= 1'b1;
      else if (flag_clr[g])
        flag_r[g] <= 1'b0;
    end
  end

  // Compare-mode level: initial state on run rise, changed by duty event.
  // io 00 leaves the level alone, so the pin holds its start value
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      level_r <= `PT_OUT_RST;
    end else if (run_rise) begin
      level_r <= output_control_bit_in;
    end else if (cmp_like & duty_evt) begin
      case (io_field_in)
        `PT_IO_01: level_r <= 1'b0;
        `PT_IO_10: level_r <= 1'b1;
        `PT_IO_11: level_r <= ~level_r;
        default:   level_r <= level_r;
      endcase
    end
  end

  // PWM active while the count lies below duty, or always if duty >= period.
  // Period 0 means 1024 counts, which no 10-bit duty can reach
  always_comb begin
    if (period_compare_value_in != `PT_CNT_ZERO &&
        duty_r >= period_compare_value_in)
      pwm_active = 1'b1;
    else
      pwm_active = cnt_r < duty_r;
  end

  // Pin next value; a fixed io level forces the pin but counting goes on.
  // Modes that release the pin park it low so the line sees only its pull.
  always_comb begin
    pin_nxt = 1'b0;
    oe_nxt  = 1'b0;
    if (mode_field_in == `PT_MODE_CMP) begin
      pin_nxt = level_r ^ polarity_bit_in;
      oe_nxt  = 1'b1;
    end else if (is_pwm) begin
      oe_nxt = 1'b1;
      case (io_field_in)
        `PT_IO_00: pin_nxt = 1'b0 ^ polarity_bit_in;
        `PT_IO_01: pin_nxt = 1'b1 ^ polarity_bit_in;
        default:   pin_nxt = (run_r & pwm_active ? output_control_bit_in :
                              ~output_control_bit_in) ^ polarity_bit_in;
      endcase
    end else if (is_pulse) begin
      oe_nxt  = 1'b1;
      pin_nxt = (run_r ? output_control_bit_in : ~output_control_bit_in)
                ^ polarity_bit_in;
    end
  end

  // Registered so the pin and its enable never glitch on mode changes
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_r <= 1'b0;
      oe_r  <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
      oe_r  <= oe_nxt;
    end
  end

  // Outputs are the registers themselves, no logic after the flops
  assign run_bit_out            = run_r;
  assign count_out              = cnt_r;
  assign duty_compare_value_out = duty_r;
  assign duty_match_flag_out    = flag_r[0];
  assign period_match_flag_out  = flag_r[1];
  assign pin_out                = pin_r;
  assign pin_oe_out             = oe_r;
endmodule

//--- pkg/periodic_timer_map.svh
// Purpose: constants for the periodic timer (field codes, widths, resets)
// Assumes: included by bare name from the package and the design
// Notes:   definitions only
`ifndef PERIODIC_TIMER_MAP_SVH
`define PERIODIC_TIMER_MAP_SVH
`define PT_CNT_W        10
`define PT_CNT_MAX      10'h3ff
`define PT_CNT_ZERO     10'h000
`define PT_MODE_CMP     2'h0
`define PT_MODE_CAP     2'h1
`define PT_MODE_PWM     2'h2
`define PT_MODE_TMR     2'h3
`define PT_IO_00        2'h0
`define PT_IO_01        2'h1
`define PT_IO_10        2'h2
`define PT_IO_11        2'h3
`define PT_OUT_RST      1'b0
`endif

//--- pkg/periodic_timer_pkg.sv
// Purpose: types for the periodic timer
// Assumes: constants come from periodic_timer_map.svh
// Notes:   none
`include "periodic_timer_map.svh"
package periodic_timer_pkg;
  typedef logic [1:0] mode_type;
  typedef logic [1:0] io_type;
  typedef logic [`PT_CNT_W-1:0] count_type;
endpackage

//--- verif/periodic_timer_monitor.sv
// Purpose: port-level checks for the periodic timer
// Assumes: one core clock domain, reset active low
// Notes:   bound to every periodic_timer instance
`timescale 1ns/10ps
module periodic_timer_monitor
  import periodic_timer_pkg::*;
(
  input wire logic      core_clk_in,
  input wire logic      rst_n_in,
  input wire logic      tick_in,
  input wire mode_type  mode_field_in,
  input wire io_type    io_field_in,
  input wire logic      run_bit_set_in,
  input wire logic      run_bit_clr_in,
  input wire logic      output_control_bit_in,
  input wire logic      polarity_bit_in,
  input wire logic      counter_clear_select_in,
  input wire logic      duty_compare_write_in,
  input wire count_type period_compare_value_in,
  input wire logic      duty_flag_clr_in,
  input wire logic      run_bit_out,
  input wire count_type count_out,
  input wire count_type duty_compare_value_out,
  input wire logic      duty_match_flag_out,
  input wire logic      period_match_flag_out,
  input wire logic      pin_out,
  input wire logic      pin_oe_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_run_clear;
    $rose(run_bit_out) |=> count_out == 10'h000;
  endproperty
  a_run_clear: assert property (p_run_clear)
    else $error("count not cleared after run start");
  property p_released;
    (mode_field_in == 2'h3 || mode_field_in == 2'h1) [*3] |-> !pin_oe_out;
  endproperty
  a_released: assert property (p_released)
    else $error("pin driven while unused");
  property p_pulse_end;
    mode_field_in == 2'h2 && io_field_in == 2'h3 && run_bit_out && tick_in
    && !run_bit_set_in && count_out == duty_compare_value_out
    |=> !run_bit_out && duty_match_flag_out;
  endproperty
  a_pulse_end: assert property (p_pulse_end)
    else $error("pulse not ended by duty match");
  property p_full_duty;
    (mode_field_in == 2'h2 && io_field_in == 2'h2 && output_control_bit_in
     && !polarity_bit_in && run_bit_out && period_compare_value_in != 0
     && duty_compare_value_out >= period_compare_value_in) [*6]
    |-> pin_out && pin_oe_out;
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("full duty output dropped");
  property p_hold;
    duty_match_flag_out && !duty_flag_clr_in |=> duty_match_flag_out;
  endproperty
  a_hold: assert property (p_hold)
    else $error("duty flag lost without clear");
  property p_cap_off;
    (mode_field_in == 2'h1 && io_field_in == 2'h3 && !duty_compare_write_in)
    [*6] |-> $stable(duty_compare_value_out);
  endproperty
  a_cap_off: assert property (p_cap_off)
    else $error("capture while disabled");
  property p_period_clear;
    (mode_field_in == 2'h1 || !counter_clear_select_in && mode_field_in != 2'h2)
    && run_bit_out && tick_in && !run_bit_clr_in
    && period_compare_value_in != 0 && count_out == period_compare_value_in
    |=> count_out == 10'h000 && period_match_flag_out;
  endproperty
  a_period_clear: assert property (p_period_clear)
    else $error("period match missed");
  property p_no_pflag;
    (mode_field_in == 2'h0 && counter_clear_select_in
     && !period_match_flag_out) [*3] |=> !period_match_flag_out;
  endproperty
  a_no_pflag: assert property (p_no_pflag)
    else $error("period flag with duty clear");
endmodule
bind periodic_timer periodic_timer_monitor mon (.core_clk_in, .rst_n_in,
  .tick_in, .mode_field_in, .io_field_in, .run_bit_set_in, .run_bit_clr_in,
  .output_control_bit_in, .polarity_bit_in, .counter_clear_select_in,
  .duty_compare_write_in, .period_compare_value_in, .duty_flag_clr_in,
  .run_bit_out, .count_out, .duty_compare_value_out, .duty_match_flag_out,
  .period_match_flag_out, .pin_out, .pin_oe_out);

//--- verif/timer_pin_env.sv
// Purpose: load on the timer pin and source of capture edges
// Assumes: the pin line carries a pull-up
// Notes:   capture edges arrive off the clock grid on purpose
`timescale 1ns/10ps
module timer_pin_env (
  input  wire logic drive_in,
  input  wire logic drive_oe_in,
  input  wire logic level_in,
  output logic      cap_out,
  output wire logic line_out
);
  // Released pin settles to the pull-up level
  assign line_out = drive_oe_in ? drive_in : 1'b1;
  always @(level_in) cap_out <= #7 level_in;
endmodule

//--- verif/periodic_timer_bench.sv
// Purpose: self-checking bench for the periodic timer
// Assumes: one tick per clock; inputs change on the falling edge
// Notes:   periods and duties drawn from a fixed seed
`timescale 1ns/10ps
module periodic_timer_bench;
  import periodic_timer_pkg::*;
  logic clk = 0, rst_n = 0, tk = 1, rs = 0, rc = 0, oc = 1, pol = 0;
  logic ccs = 0, lvl = 0, dw = 0, dc = 0, pc = 0, run, dfl, pfl, pin;
  logic oe, cap, line;
  mode_type md = 0;
  io_type io = 0;
  count_type dv = 0, pv = 0, cnt, dq;
  int n_mismatch = 0, compares = 0, cyc = 0, hi, p, d;
  periodic_timer dut (.core_clk_in(clk), .rst_n_in(rst_n), .tick_in(tk),
    .mode_field_in(md), .io_field_in(io), .run_bit_set_in(rs),
    .run_bit_clr_in(rc), .output_control_bit_in(oc),
    .polarity_bit_in(pol), .counter_clear_select_in(ccs),
    .capture_source_select_in(1'b0), .capture_input_pin_in(cap),
    .duty_compare_value_in(dv), .duty_compare_write_in(dw),
    .period_compare_value_in(pv), .duty_flag_clr_in(dc),
    .period_flag_clr_in(pc), .run_bit_out(run), .count_out(cnt),
    .duty_compare_value_out(dq), .duty_match_flag_out(dfl),
    .period_match_flag_out(pfl), .pin_out(pin), .pin_oe_out(oe));
  timer_pin_env env (.drive_in(pin), .drive_oe_in(oe), .level_in(lvl),
    .cap_out(cap), .line_out(line));
  initial forever #25 clk = ~clk;
  task automatic results;
    if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input logic [11:0] a, input logic [11:0] e);
    compares++;
    if (a !== e) begin
      n_mismatch++;
      $display("mismatch %0t got %0h want %0h", $time, a, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    step(1);
    s = 0;
  endtask
  task automatic go;
    pulse(rc);
    pulse(rs);
  endtask
  task automatic clrf;
    dc = 1;
    pc = 1;
    step(1);
    dc = 0;
    pc = 0;
  endtask
  // High samples over three whole periods, output control high
  function automatic int exp_hi(int p, int d, io_type i, logic v);
    int n, a;
    n = (p == 0) ? 1024 : p;
    a = (i == 2'h0) ? 0 : (i == 2'h1 || d >= n) ? n : d;
    return 3 * (v ? n - a : a);
  endfunction
  initial begin
    void'($urandom(32'hfa4f));
    step(2);
    rst_n = 1;
    step(1);
    for (int k = 0; k < 3; k++) begin
      md = (k == 2) ? 2'h3 : 2'h0;
      ccs = (k == 1);
      p = 4 + $urandom % 16;
      d = 1 + $urandom % (p - 1);
      pv = 10'(p);
      dv = 10'(d);
      pulse(dw);
      go();
      clrf();
      hi = 0;
      repeat (2 * p + 4) begin
        step(1);
        if (cnt > (ccs ? d : p)) hi++;
      end
      chk(12'(hi), 12'h000);
      chk({dfl, pfl}, {1'b1, !ccs});
      if (k == 2) chk(line, 1'b1);
      chk(oe, k != 2);
    end
    md = 2'h2;
    p = 8 + $urandom % 40;
    d = 1 + $urandom % (p - 1);
    for (int r = 0; r < 6; r++) begin
      io = (r == 3) ? 2'h0 : (r == 4) ? 2'h1 : 2'h2;
      pol = (r == 1);
      pv = (r == 5) ? 10'h000 : 10'(p);
      dv = (r == 2) ? 10'(p) : (r == 5) ? 10'h200 : 10'(d);
      pulse(dw);
      go();
      step(4);
      clrf();
      hi = 0;
      repeat (exp_hi(int'(pv), 0, 2'h1, 1'b0)) begin
        step(1);
        if (pin === 1'b1) hi++;
      end
      chk(12'(hi), 12'(exp_hi(int'(pv), int'(dv), io, pol)));
      chk(pfl, 1'b1);
    end
    io = 2'h3;
    pol = 0;
    pv = 10'h002;
    d = 6 + $urandom % 20;
    dv = 10'(d);
    pulse(dw);
    clrf();
    go();
    step(4);
    chk({run, pin}, 2'b11);
    step(d + 3);
    chk({run, dfl, pin}, 3'b010);
    dv = 10'h12c;
    pulse(dw);
    pulse(rs);
    step(3);
    pulse(rc);
    step(3);
    chk({run, pin}, 2'b00);
    md = 2'h1;
    pv = 10'h000;
    for (int i = 0; i < 4; i++) begin
      io = 2'(i);
      lvl = 0;
      go();
      step(3 + $urandom % 20);
      clrf();
      lvl = 1;
      step(6);
      chk(dfl, i == 0 || i == 2);
      chk(oe, 1'b0);
      if (dfl === 1'b1) chk(cnt - dq < 10'd9, 1'b1);
      clrf();
      lvl = 0;
      step(6);
      chk(dfl, i == 1 || i == 2);
    end
    rst_n = 0;
    step(1);
    rst_n = 1;
    step(1);
    chk({dfl, pfl, cnt}, 12'h000);
    chk(run, 1'b0);
    results();
  end
endmodule
